// [sbl_pkg.sv]
// sbl_pkg: constants for the serial boot packet loader
package sbl_pkg;
	localparam logic [7:0] ACK_BYTE        = 8'hCC;
	localparam logic [7:0] NAK_BYTE        = 8'h33;
	localparam logic [7:0] CMD_PING        = 8'h20;
	localparam logic [7:0] CMD_DOWNLOAD    = 8'h21;
	localparam logic [7:0] CMD_RUN         = 8'h22;
	localparam logic [7:0] CMD_QUERY       = 8'h23;
	localparam logic [7:0] CMD_SEND_DATA   = 8'h24;
	localparam logic [7:0] CMD_RESET       = 8'h25;
	localparam logic [7:0] LEN_PING        = 8'h03;
	localparam logic [7:0] LEN_DOWNLOAD    = 8'h0B;
	localparam logic [7:0] LEN_RUN         = 8'h07;
	localparam logic [7:0] LEN_RESET       = 8'h03;
	localparam logic [7:0] LEN_QUERY_REPLY = 8'h03;
	localparam logic [7:0] LEN_MIN         = 8'h03;
	localparam logic [7:0] LEN_MAX         = 8'h0B;
	localparam logic [7:0] STAT_SUCCESS    = 8'h40;
	localparam logic [7:0] STAT_UNKNOWN    = 8'h41;
	localparam logic [7:0] STAT_INVALID    = 8'h42;
	localparam logic [7:0] STAT_FLASH_FAIL = 8'h43;
	localparam logic [7:0] STAT_RESET_VAL  = 8'h40;
	localparam int         FIFO_DEPTH      = 8;
	localparam int         FIFO_WIDTH      = 8;
	localparam logic [1:0] IF_NONE         = 2'h0;
	localparam logic [1:0] IF_UART         = 2'h1;
	localparam logic [1:0] IF_SSI          = 2'h2;
endpackage : sbl_pkg

// [sbl_fifo.sv]
// sbl_fifo: small valid/ready byte fifo
`timescale 1ns/10ps
`default_nettype none
module sbl_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_b,
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	output logic                  o_out_valid,
	output logic      [WIDTH-1:0] o_out_data,
	input  wire logic             i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed
	{
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0]   cnt;
	} sbl_fifo_st_type;
	sbl_fifo_st_type st_ff;
	sbl_fifo_st_type nxt_st;
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic push;
	logic pop;
	assign o_in_ready  = (st_ff.cnt != (AW+1)'(DEPTH));
	assign o_out_valid = (st_ff.cnt != '0);
	assign o_out_data  = mem_ff[st_ff.rd];
	assign push = i_in_valid && o_in_ready;
	assign pop  = o_out_valid && i_out_ready;
	always_comb
	begin
		nxt_st = st_ff;
		if (push)
		begin
			nxt_st.wr = st_ff.wr + 1'b1;
		end
		if (pop)
		begin
			nxt_st.rd = st_ff.rd + 1'b1;
		end
		nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			st_ff <= '0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end
	always_ff @(posedge i_clk)
	begin
		if (push)
		begin
			mem_ff[st_ff.wr] <= i_in_data;
		end
	end
	AST_FIFO_NO_OVERFLOW: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		st_ff.cnt <= (AW+1)'(DEPTH))
		else $error("fifo full but ready");
endmodule : sbl_fifo
`default_nettype wire

// [sbl_loader.sv]
// sbl_loader: packet command interpreter of the serial loader
`timescale 1ns/10ps
`default_nettype none
// How it works
// - answer each packet with CC or 33
// - ack reflects framing only, not command
// - reply: size, checksum, then payload
// - reply bytes sent back to back
// - skip zero bytes awaiting host ack
// - first payload byte is the command
// - ping sets status success
// - query returns one-byte status packet
// - download latches address and count
// - erase whole region before ack
// - program data, advance address
// - stop programming at byte count
// - nak leaves address unchanged
// - ack before run transfer
// - ack before software reset
// - size byte counts whole packet
// - checksum sums payload only
// - ssi mode three, host clocks
// - first active interface locks out other
module sbl_loader (
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_uart_rx_valid,
	input  wire logic [7:0]  i_uart_rx_data,
	input  wire logic        i_ssi_rx_valid,
	input  wire logic [7:0]  i_ssi_rx_data,
	output logic             o_tx_valid,
	output logic [7:0]       o_tx_data,
	output logic [1:0]       o_tx_port,
	input  wire logic        i_tx_ready,
	output logic             o_erase_req,
	output logic [31:0]      o_erase_addr,
	output logic [31:0]      o_erase_len,
	input  wire logic        i_erase_done,
	input  wire logic        i_erase_ok,
	output logic             o_prog_req,
	output logic [31:0]      o_prog_addr,
	output logic [7:0]       o_prog_data,
	input  wire logic        i_prog_done,
	input  wire logic        i_prog_ok,
	output logic             o_run_req,
	output logic [31:0]      o_run_addr,
	output logic             o_reset_req
);
	import sbl_pkg::*;
	//----------------------------------------
	// state
	//----------------------------------------
	typedef enum logic [3:0] {
		ST_SIZE  = 4'b0000,
		ST_SUM   = 4'b0001,
		ST_DATA  = 4'b0010,
		ST_ERASE = 4'b0011,
		ST_ANS   = 4'b0100,
		ST_PROG  = 4'b0101,
		ST_REP   = 4'b0110,
		ST_HACK  = 4'b0111,
		ST_DONE  = 4'b1000
	} sbl_state_type;
	typedef struct packed
	{
		sbl_state_type st;
		logic [1:0]    port;
		logic [7:0]    len;
		logic [7:0]    sum;
		logic [7:0]    calc;
		logic [3:0]    idx;
		logic [7:0]    cmd;
		logic [31:0]   p0;
		logic [31:0]   p1;
		logic [63:0]   dbuf;
		logic [31:0]   addr;
		logic [31:0]   remain;
		logic          dl_ok;
		logic [7:0]    status;
		logic [7:0]    ans;
		logic          ans_v;
		logic [1:0]    rep_i;
		logic          erase_req;
		logic          prog_req;
		logic [3:0]    prog_n;
		logic [7:0]    pdata;
		logic          run_req;
		logic          reset_req;
	} sbl_loader_st_type;
	sbl_loader_st_type st_ff;
	sbl_loader_st_type nxt_st;
	//----------------------------------------
	// receive path
	//----------------------------------------
	logic       rx_v;
	logic [7:0] rx_d;
	logic       fifo_in_ready;
	logic       q_valid;
	logic [7:0] q_data;
	logic       q_ready;
	always_comb
	begin
		rx_v = 1'b0;
		rx_d = 8'h00;
		if ((st_ff.port != IF_SSI) && i_uart_rx_valid)
		begin
			rx_v = 1'b1;
			rx_d = i_uart_rx_data;
		end
		else if ((st_ff.port != IF_UART) && i_ssi_rx_valid)
		begin
			rx_v = 1'b1;
			rx_d = i_ssi_rx_data;
		end
	end
	sbl_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clk       (i_clk),
		.i_rst_b     (i_rst_b),
		.i_in_valid  (rx_v),
		.i_in_data   (rx_d),
		.o_in_ready  (fifo_in_ready),
		.o_out_valid (q_valid),
		.o_out_data  (q_data),
		.i_out_ready (q_ready)
	);
	assign q_ready = (st_ff.st == ST_SIZE) || (st_ff.st == ST_SUM)
		|| (st_ff.st == ST_DATA) || (st_ff.st == ST_HACK);
	//----------------------------------------
	// next state
	//----------------------------------------
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.erase_req = 1'b0;
		nxt_st.prog_req = 1'b0;
		if (st_ff.port == IF_NONE)
		begin
			if (i_uart_rx_valid)
			begin
				nxt_st.port = IF_UART;
			end
			else if (i_ssi_rx_valid)
			begin
				nxt_st.port = IF_SSI;
			end
		end
		case (st_ff.st)
			ST_SIZE:
			begin
				if (q_valid && (q_data >= LEN_MIN) && (q_data <= LEN_MAX))
				begin
					nxt_st.len = q_data;
					nxt_st.idx = 4'h0;
					nxt_st.calc = 8'h00;
					nxt_st.st = ST_SUM;
				end
			end
			ST_SUM:
			begin
				if (q_valid)
				begin
					nxt_st.sum = q_data;
					nxt_st.st = ST_DATA;
				end
			end
			ST_DATA:
			begin
				if (q_valid)
				begin
					nxt_st.calc = st_ff.calc + q_data;
					nxt_st.idx = st_ff.idx + 4'h1;
					if (st_ff.idx == 4'h0)
					begin
						nxt_st.cmd = q_data;
					end
					else if (st_ff.idx < 4'h5)
					begin
						nxt_st.p0 = {st_ff.p0[23:0], q_data};
					end
					else
					begin
						nxt_st.p1 = {st_ff.p1[23:0], q_data};
					end
					if (st_ff.idx != 4'h0)
					begin
						nxt_st.dbuf = {st_ff.dbuf[55:0], q_data};
					end
					if ({4'h0, st_ff.idx} == st_ff.len - 8'h03)
					begin
						nxt_st.ans_v = 1'b1;
						nxt_st.st = ST_ANS;
						if ((st_ff.calc + q_data) != st_ff.sum)
						begin
							nxt_st.ans = NAK_BYTE;
						end
						else
						begin
							nxt_st.ans = ACK_BYTE;
							if ((st_ff.idx == 4'h0) && (q_data == CMD_PING))
							begin
								nxt_st.status = STAT_SUCCESS;
							end
							else if ((st_ff.idx == 4'h8) && (st_ff.cmd == CMD_DOWNLOAD))
							begin
								nxt_st.ans_v = 1'b0;
								nxt_st.erase_req = 1'b1;
								nxt_st.st = ST_ERASE;
							end
							else if ((st_ff.idx != 4'h0) && (st_ff.cmd == CMD_SEND_DATA))
							begin
								if (st_ff.dl_ok)
								begin
									nxt_st.prog_n = st_ff.idx;
								end
								else
								begin
									nxt_st.status = STAT_INVALID;
								end
							end
							else if ((st_ff.idx == 4'h4) && (st_ff.cmd == CMD_RUN))
							begin
								nxt_st.status = STAT_SUCCESS;
							end
							else if ((st_ff.idx == 4'h0) && (q_data == CMD_RESET))
							begin
								nxt_st.status = STAT_SUCCESS;
							end
							else if (!((st_ff.idx == 4'h0) && (q_data == CMD_QUERY)))
							begin
								nxt_st.status = STAT_UNKNOWN;
							end
						end
					end
				end
			end
			ST_ERASE:
			begin
				if (i_erase_done)
				begin
					nxt_st.addr = st_ff.p0;
					nxt_st.remain = st_ff.p1;
					nxt_st.dl_ok = i_erase_ok;
					nxt_st.status = i_erase_ok ? STAT_SUCCESS : STAT_FLASH_FAIL;
					nxt_st.ans = ACK_BYTE;
					nxt_st.ans_v = 1'b1;
					nxt_st.st = ST_ANS;
				end
			end
			ST_ANS:
			begin
				if (i_tx_ready)
				begin
					nxt_st.ans_v = 1'b0;
					nxt_st.st = ST_SIZE;
					if (st_ff.ans == ACK_BYTE)
					begin
						if (st_ff.cmd == CMD_QUERY)
						begin
							nxt_st.rep_i = 2'd0;
							nxt_st.ans_v = 1'b1;
							nxt_st.st = ST_REP;
						end
						else if ((st_ff.cmd == CMD_SEND_DATA) && (st_ff.prog_n != 4'h0))
						begin
							nxt_st.st = ST_PROG;
							nxt_st.status = STAT_SUCCESS;
						end
						else if ((st_ff.cmd == CMD_RUN) && (st_ff.len == LEN_RUN))
						begin
							nxt_st.run_req = 1'b1;
							nxt_st.st = ST_DONE;
						end
						else if ((st_ff.cmd == CMD_RESET) && (st_ff.len == LEN_RESET))
						begin
							nxt_st.reset_req = 1'b1;
							nxt_st.st = ST_DONE;
						end
					end
				end
			end
			ST_PROG:
			begin
				if ((st_ff.prog_n == 4'h0) || (st_ff.remain == 32'h0000_0000))
				begin
					nxt_st.prog_n = 4'h0;
					nxt_st.st = ST_SIZE;
				end
				else if (st_ff.prog_req && i_prog_done)
				begin
					nxt_st.addr = st_ff.addr + 32'h0000_0001;
					nxt_st.remain = st_ff.remain - 32'h0000_0001;
					nxt_st.prog_n = st_ff.prog_n - 4'h1;
					if (!i_prog_ok)
					begin
						nxt_st.status = STAT_FLASH_FAIL;
					end
				end
				else
				begin
					nxt_st.prog_req = 1'b1;
					nxt_st.pdata = 8'(st_ff.dbuf >> {st_ff.prog_n - 4'h1, 3'b000});
				end
			end
			ST_REP:
			begin
				if (i_tx_ready)
				begin
					nxt_st.rep_i = st_ff.rep_i + 2'd1;
					if (st_ff.rep_i == 2'd2)
					begin
						nxt_st.ans_v = 1'b0;
						nxt_st.st = ST_HACK;
					end
				end
			end
			ST_HACK:
			begin
				if (q_valid && (q_data != 8'h00))
				begin
					nxt_st.st = ST_SIZE;
				end
			end
			ST_DONE:
			begin
				nxt_st.st = ST_DONE;
			end
			default:
			begin
				nxt_st.st = ST_SIZE;
			end
		endcase
	end
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			st_ff <= '0;
			st_ff.status <= STAT_RESET_VAL;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end
	//----------------------------------------
	// outputs
	//----------------------------------------
	logic [7:0]  tx_data_ff;
	logic [7:0]  nxt_tx_data;
	always_comb
	begin
		case (st_ff.rep_i)
			2'd0:    nxt_tx_data = LEN_QUERY_REPLY;
			default: nxt_tx_data = st_ff.status;
		endcase
		if (nxt_st.st == ST_ANS)
		begin
			nxt_tx_data = nxt_st.ans;
		end
		else if (nxt_st.st == ST_REP)
		begin
			nxt_tx_data = (nxt_st.rep_i == 2'd0) ? LEN_QUERY_REPLY : st_ff.status;
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			tx_data_ff <= 8'h00;
		end
		else
		begin
			tx_data_ff <= nxt_tx_data;
		end
	end
	assign o_tx_valid   = st_ff.ans_v;
	assign o_tx_data    = tx_data_ff;
	assign o_tx_port    = st_ff.port;
	assign o_erase_req  = st_ff.erase_req;
	assign o_erase_addr = st_ff.p0;
	assign o_erase_len  = st_ff.p1;
	assign o_prog_req   = st_ff.prog_req;
	assign o_prog_addr  = st_ff.addr;
	assign o_prog_data  = st_ff.pdata;
	assign o_run_req    = st_ff.run_req;
	assign o_run_addr   = st_ff.p0;
	assign o_reset_req  = st_ff.reset_req;
	//----------------------------------------
	// checks
	//----------------------------------------
	AST_ANS_BYTE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(st_ff.st == ST_ANS) |-> ((o_tx_data == ACK_BYTE) || (o_tx_data == NAK_BYTE)))
		else $error("answer byte not ack or nak");
	AST_RUN_AFTER_ACK: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		$rose(o_run_req) |-> $past(st_ff.st) == ST_ANS)
		else $error("run without ack");
	AST_RESET_AFTER_ACK: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		$rose(o_reset_req) |-> $past(st_ff.st) == ST_ANS)
		else $error("reset without ack");
	AST_NAK_KEEPS_ADDR: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(st_ff.st == ST_ANS && o_tx_data == NAK_BYTE) |=> $stable(st_ff.addr))
		else $error("address moved on nak");
	AST_REPLY_CONSEC: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(st_ff.st == ST_REP) |-> o_tx_valid)
		else $error("gap in reply");
	AST_REPLY_SIZE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(st_ff.st == ST_REP && st_ff.rep_i == 2'd0) |-> o_tx_data == LEN_QUERY_REPLY)
		else $error("reply does not start with size");
	AST_ERASE_BEFORE_ACK: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_erase_req |=> (st_ff.st == ST_ERASE) && !o_tx_valid)
		else $error("ack before erase");
	AST_LOCKOUT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(st_ff.port == IF_UART) |=> (st_ff.port == IF_UART))
		else $error("interface lock lost");
	AST_RX_NO_DROP: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		rx_v |-> fifo_in_ready)
		else $error("receive byte dropped");
	COV_PING: cover property (@(posedge i_clk) st_ff.st == ST_ANS && st_ff.cmd == CMD_PING);
	COV_QUERY: cover property (@(posedge i_clk) st_ff.st == ST_HACK);
	COV_PROG: cover property (@(posedge i_clk) o_prog_req);
	COV_RUN: cover property (@(posedge i_clk) o_run_req);
endmodule : sbl_loader
`default_nettype wire

// [sbl_host.sv]
// sbl_host: host side of the serial link, sends packets and collects replies
`timescale 1ns/10ps
`default_nettype none
module sbl_host (
	input  wire logic       i_clk,
	input  wire logic       i_tx_valid,
	input  wire logic [7:0] i_tx_data,
	input  wire logic       i_tx_ready,
	output logic            o_uart_valid,
	output logic [7:0]      o_uart_data,
	output logic            o_ssi_valid,
	output logic [7:0]      o_ssi_data
);
	logic [7:0] rx_q[$];
	initial
	begin
		o_uart_valid = 1'b0;
		o_uart_data  = 8'h00;
		o_ssi_valid  = 1'b0;
		o_ssi_data   = 8'h00;
	end
	// -----------------------------
	// reply capture
	// -----------------------------
	always @(posedge i_clk)
		if (i_tx_valid && i_tx_ready)
			rx_q.push_back(i_tx_data);
	// -----------------------------
	// byte and packet send
	// -----------------------------
	task automatic send_byte(input logic ssi, input logic [7:0] b);
		@(posedge i_clk);
		#1;
		o_uart_valid = !ssi;
		o_ssi_valid  = ssi;
		o_uart_data  = ssi ? ~o_uart_data : b;
		o_ssi_data   = ssi ? b : ~o_ssi_data;
		@(posedge i_clk);
		#1;
		o_uart_valid = 1'b0;
		o_ssi_valid  = 1'b0;
		o_uart_data  = ~o_uart_data;
		o_ssi_data   = ~o_ssi_data;
		repeat (2) @(posedge i_clk);
	endtask : send_byte
	task automatic send_pkt(input logic ssi, input logic [7:0] pl[$], input logic [7:0] adj);
		logic [7:0] sum;
		sum = adj;
		foreach (pl[i])
			sum += pl[i];
		send_byte(ssi, 8'(pl.size() + 2));
		send_byte(ssi, sum);
		foreach (pl[i])
			send_byte(ssi, pl[i]);
	endtask : send_pkt
endmodule : sbl_host
`default_nettype wire

// [tb_top.sv]
// tb_top: self-checking bench of the serial loader
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import sbl_pkg::*;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        tx_ready = 1'b0;
	logic        erase_done = 1'b0;
	logic        prog_done = 1'b0;
	logic        uv, sv, tv, er, pr, rr, sr;
	logic [7:0]  ud, sd, td, pd;
	logic [1:0]  tp;
	logic [31:0] ea, el, pa, ra, a;
	logic [31:0] lfsr = 32'h5bac_0f70;
	logic [31:0] nxt_addr;
	logic [63:0] er_q[$];
	logic [39:0] pr_q[$];
	logic [7:0]  pl[$];
	int          num_errors = 0;
	int          comparisons = 0;
	int          er_cnt = 0;
	int          early = 0;
	int          acked = 1;
	always #10 clk = ~clk;
	sbl_loader DUT (.i_clk(clk), .i_rst_b(rst_b), .i_uart_rx_valid(uv), .i_uart_rx_data(ud),
		.i_ssi_rx_valid(sv), .i_ssi_rx_data(sd), .o_tx_valid(tv), .o_tx_data(td),
		.o_tx_port(tp), .i_tx_ready(tx_ready), .o_erase_req(er), .o_erase_addr(ea),
		.o_erase_len(el), .i_erase_done(erase_done), .i_erase_ok(1'b1), .o_prog_req(pr),
		.o_prog_addr(pa), .o_prog_data(pd), .i_prog_done(prog_done), .i_prog_ok(1'b1),
		.o_run_req(rr), .o_run_addr(ra), .o_reset_req(sr));
	sbl_host HOST (.i_clk(clk), .i_tx_valid(tv), .i_tx_data(td), .i_tx_ready(tx_ready),
		.o_uart_valid(uv), .o_uart_data(ud), .o_ssi_valid(sv), .o_ssi_data(sd));
	function automatic logic [31:0] lfsr_step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_step
	// -----------------------------
	// flash responder and stalls
	// -----------------------------
	always @(posedge clk)
	begin
		#1;
		lfsr = lfsr_step(lfsr);
		tx_ready = lfsr[0] | lfsr[5];
		if (er)
		begin
			er_q.push_back({ea, el});
			er_cnt = 20;
		end
		else if (er_cnt > 0)
			er_cnt--;
		erase_done = er_cnt == 1;
		if ((rr || sr) && acked == 0 && HOST.rx_q.size() == 0)
			early++;
		prog_done = pr && !prog_done;
		if (prog_done)
			pr_q.push_back({pa, pd});
	end
	// -----------------------------
	// compare and link tasks
	// -----------------------------
	task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp_byte
	task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp_word
	task automatic complete_run();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run
	task automatic get_byte(input logic skip0, output logic [7:0] b);
		int n;
		b = 8'h00;
		for (n = 0; n < 4000; n++)
		begin
			@(posedge clk);
			#2;
			if (HOST.rx_q.size() > 0)
			begin
				b = HOST.rx_q.pop_front();
				if (b !== 8'h00 || !skip0)
					break;
			end
		end
		acked = 1;
		if (n == 4000)
		begin
			num_errors++;
			$display("mismatch reply expected byte seen none");
			complete_run();
		end
	endtask : get_byte
	task automatic cmd(input logic ssi, input logic [7:0] p[$], input logic [7:0] adj,
		input logic [7:0] ack);
		logic [7:0] b;
		HOST.send_pkt(ssi, p, adj);
		get_byte(1'b1, b);
		cmp_byte("ack", ack, b);
	endtask : cmd
	task automatic query(input logic [7:0] st, input logic [7:0] hk = ACK_BYTE);
		logic [7:0] b;
		cmd(1'b0, '{CMD_QUERY}, 8'h00, ACK_BYTE);
		get_byte(1'b1, b);
		cmp_byte("reply size", LEN_QUERY_REPLY, b);
		get_byte(1'b0, b);
		cmp_byte("reply sum", st, b);
		get_byte(1'b0, b);
		cmp_byte("status", st, b);
		HOST.send_byte(1'b0, 8'h00);
		HOST.send_byte(1'b0, hk);
	endtask : query
	task automatic mk(input logic [7:0] c, input logic [63:0] w, input int nb);
		pl = '{c};
		for (int i = nb - 1; i >= 0; i--)
			pl.push_back(w[i*8+:8]);
	endtask : mk
	task automatic send_data(input int n, input logic [7:0] adj, input logic [7:0] ack,
		input int np);
		pl = '{CMD_SEND_DATA};
		for (int i = 0; i < n; i++)
		begin
			lfsr = lfsr_step(lfsr);
			pl.push_back(lfsr[15:8]);
		end
		cmd(1'b0, pl, adj, ack);
		for (int k = 0; k < 400 && pr_q.size() < np; k++)
			@(posedge clk);
		repeat (20) @(posedge clk);
		cmp_word("prog count", np, pr_q.size());
		for (int i = 0; i < np && i < pr_q.size(); i++)
		begin
			cmp_word("prog addr", nxt_addr + i, pr_q[i][39:8]);
			cmp_byte("prog data", pl[i+1], pr_q[i][7:0]);
		end
		nxt_addr += np;
		pr_q.delete();
	endtask : send_data
	task automatic do_reset();
		#1;
		rst_b = 1'b0;
		repeat (10) @(posedge clk);
		#1;
		rst_b = 1'b1;
	endtask : do_reset
	// -----------------------------
	// main sequence
	// -----------------------------
	initial
	begin
		do_reset();
		cmd(1'b0, '{CMD_PING}, 8'h00, ACK_BYTE);
		query(STAT_SUCCESS);
		cmp_word("port", {30'h0, IF_UART}, {30'h0, tp});
		cmd(1'b0, '{CMD_PING}, 8'h01, NAK_BYTE);
		cmd(1'b0, '{8'h27, lfsr[7:0]}, 8'h00, ACK_BYTE);
		query(STAT_UNKNOWN, NAK_BYTE);
		query(STAT_UNKNOWN);
		nxt_addr = 32'h0000_0000;
		send_data(1, 8'h00, ACK_BYTE, 0);
		query(STAT_INVALID);
		$display("test command set done");
		a = {16'h0000, lfsr[15:2], 2'b00};
		mk(CMD_DOWNLOAD, {a, 32'h0000_000a}, 8);
		cmd(1'b0, pl, 8'h00, ACK_BYTE);
		cmp_word("erase pending", 0, er_cnt);
		cmp_word("erase count", 1, er_q.size());
		cmp_word("erase addr", a, er_q[0][63:32]);
		cmp_word("erase len", 32'h0000_000a, er_q[0][31:0]);
		query(STAT_SUCCESS);
		nxt_addr = a;
		send_data(6, 8'h00, ACK_BYTE, 6);
		send_data(4, 8'h01, NAK_BYTE, 0);
		send_data(6, 8'h00, ACK_BYTE, 4);
		query(STAT_SUCCESS);
		$display("test download done");
		acked = 0;
		mk(CMD_RUN, {32'h0000_0000, a}, 4);
		cmd(1'b0, pl, 8'h00, ACK_BYTE);
		for (int k = 0; k < 200 && rr !== 1'b1; k++)
			@(posedge clk);
		cmp_word("run req", 1, {31'h0, rr});
		cmp_word("run addr", a, ra);
		do_reset();
		acked = 0;
		cmd(1'b0, '{CMD_RESET}, 8'h00, ACK_BYTE);
		for (int k = 0; k < 200 && sr !== 1'b1; k++)
			@(posedge clk);
		cmp_word("reset req", 1, {31'h0, sr});
		cmp_word("early action", 0, early);
		$display("test run and reset done");
		do_reset();
		cmd(1'b1, '{CMD_PING}, 8'h00, ACK_BYTE);
		cmp_word("port", {30'h0, IF_SSI}, {30'h0, tp});
		HOST.send_pkt(1'b0, '{CMD_PING}, 8'h00);
		repeat (100) @(posedge clk);
		cmp_word("locked out", 0, HOST.rx_q.size());
		$display("test port lock done");
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
